// file: cmp_pkg.sv
// package: offsets, field positions and reset values for mask and port block
package cmp_pkg;
  // printed offsets are not all multiples of four: they are word indices
  localparam logic [11:0] IDX_MASK_4 = 12'h11c;
  localparam logic [11:0] IDX_MASK_5 = 12'h11d;
  localparam logic [11:0] IDX_MASK_6 = 12'h11e;
  localparam logic [11:0] IDX_MASK_7 = 12'h11f;
  localparam logic [11:0] IDX_PORT_CTRL = 12'h13d;
  localparam logic [11:0] IDX_PORT_DATA = 12'h13e;
  localparam logic [11:0] IDX_PORT_DIR = 12'h13f;
  localparam logic [11:0] IDX_MASK_0 = 12'h114;
  localparam logic [11:0] IDX_MASK_1 = 12'h115;
  localparam logic [11:0] IDX_MASK_2 = 12'h116;
  localparam logic [11:0] IDX_MASK_3 = 12'h117;
  localparam logic [11:0] IDX_CODE_0 = 12'h110;
  localparam logic [11:0] IDX_MODULE_CTRL_0 = 12'h180;
  localparam int CTRL_PULL_BIT = 1;
  localparam int CTRL_REDUCED_BIT = 0;
  localparam int MCR0_SOFT_RESET_BIT = 0;
  localparam logic [7:0] PORT_CTRL_RESET = 8'h00;
  localparam logic [7:0] PORT_DIR_RESET = 8'h00;
  localparam logic [7:0] PORT_DATA_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic MCR0_RESET = 1'b1;
  localparam int TX_PIN = 1;
  localparam int RX_PIN = 0;
endpackage : cmp_pkg

// file: cmp_mask_port.sv
// identifier mask, acceptance code and spare port logic with apb slave
`timescale 1ns/100ps
module cmp_mask_port
  import cmp_pkg::*;
#(
  parameter int NUM_FILTERS = 8
)
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [13:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [31:0] i_received_identifier_byte,
  input wire logic i_identifier_valid,
  output logic o_accept_lo,
  output logic o_accept_hi,
  input wire logic i_tx_level,
  output logic o_can_transmit_pin,
  input wire logic i_can_receive_pin,
  input wire logic [7:2] i_port_pin,
  output logic [7:2] o_port_pin,
  output logic [7:2] o_port_pin_oe_n,
  output logic o_pull_enable,
  output logic o_reduced_drive_enable,
  output logic o_soft_reset_request
);

  function automatic logic bank_hit(input logic [31:0] code,
                                    input logic [31:0] mask,
                                    input logic [31:0] ident);
    // compare first, then let set mask bits force don't-care positions to match
    bank_hit = &((~(code ^ ident)) | mask);
  endfunction : bank_hit

  logic [7:0] mask [NUM_FILTERS];
  logic [7:0] code [NUM_FILTERS];
  logic [7:0] next_mask [NUM_FILTERS];
  logic [7:0] next_code [NUM_FILTERS];
  logic [1:0] port_ctrl;
  logic [1:0] next_port_ctrl;
  logic [7:2] port_latch;
  logic [7:2] next_port_latch;
  logic [7:2] port_dir;
  logic [7:2] next_port_dir;
  logic soft_reset_request;
  logic next_soft_reset_request;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic pready;
  logic next_pready;
  logic pslverr;
  logic next_pslverr;
  logic accept_lo;
  logic accept_hi;
  logic next_accept_lo;
  logic next_accept_hi;
  logic [7:2] pin_meta;
  logic [7:2] pin_sync;
  logic [1:0] can_meta;
  logic [1:0] can_sync;
  logic [7:2] pin_out;
  logic [7:2] pin_oe_n;
  logic can_tx;

  logic [11:0] word_idx;
  logic access;
  logic commit;
  logic wr;
  logic mapped;
  logic [7:0] wbyte;
  logic [3:0] bank_off;
  logic [2:0] bank_sel;
  assign word_idx = i_paddr[13:2];
  assign access = i_psel && i_penable && !pready;
  // writes land only at the edge where the master sees pready high
  assign commit = i_psel && i_penable && pready;
  assign wr = commit && i_pwrite && i_pstrb[0];
  assign bank_off = word_idx[3:0] - IDX_CODE_0[3:0];
  assign bank_sel = {bank_off[3], bank_off[1:0]};
  assign wbyte = i_pwdata[7:0];

  // pins from outside pass two flops before any logic reads them
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      can_meta <= '0;
      can_sync <= '0;
    end
    else
    begin
      pin_meta <= i_port_pin;
      pin_sync <= pin_meta;
      can_meta <= {i_tx_level, i_can_receive_pin};
      can_sync <= can_meta;
    end
  end

  always_comb
  begin
    next_mask = mask;
    next_code = code;
    next_port_ctrl = port_ctrl;
    next_port_latch = port_latch;
    next_port_dir = port_dir;
    next_soft_reset_request = soft_reset_request;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    mapped = 1'b1;
    if (access || commit)
    begin
      next_pready = access;
      next_prdata = 32'h0000_0000;
      if (word_idx >= IDX_CODE_0 && word_idx <= IDX_MASK_7)
      begin
        // banks: codes 0-3, masks 0-3, codes 4-7, masks 4-7
        if (bank_off[2])
        begin
          next_prdata = {24'h000000, mask[bank_sel]};
          if (wr && soft_reset_request)
            next_mask[bank_sel] = wbyte;
        end
        else
        begin
          next_prdata = {24'h000000, code[bank_sel]};
          if (wr && soft_reset_request)
            next_code[bank_sel] = wbyte;
        end
      end
      else
      begin
        case (word_idx)
          IDX_PORT_CTRL:
          begin
            next_prdata = {30'h0000_0000, port_ctrl};
            if (wr)
              next_port_ctrl = wbyte[1:0];
          end
          IDX_PORT_DATA:
          begin
            next_prdata = {24'h000000,
                           (port_latch & port_dir) | (pin_sync & ~port_dir),
                           can_sync};
            if (wr)
              next_port_latch = wbyte[7:2];
          end
          IDX_PORT_DIR:
          begin
            next_prdata = {24'h000000, port_dir, 2'b00};
            if (wr)
              next_port_dir = wbyte[7:2];
          end
          IDX_MODULE_CTRL_0:
          begin
            next_prdata = {31'h0000_0000, soft_reset_request};
            if (wr)
              next_soft_reset_request = wbyte[MCR0_SOFT_RESET_BIT];
          end
          default:
            mapped = 1'b0;
        endcase
      end
      next_pslverr = access && !mapped;
    end
  end

  always_comb
  begin
    next_accept_lo = accept_lo;
    next_accept_hi = accept_hi;
    if (i_identifier_valid)
    begin
      next_accept_lo = bank_hit({code[0], code[1], code[2], code[3]},
                                {mask[0], mask[1], mask[2], mask[3]},
                                i_received_identifier_byte);
      next_accept_hi = bank_hit({code[4], code[5], code[6], code[7]},
                                {mask[4], mask[5], mask[6], mask[7]},
                                i_received_identifier_byte);
    end
    // only spare pins take latch and enable; no drive while input
    pin_out = port_latch;
    pin_oe_n = ~port_dir;
    can_tx = i_tx_level;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      for (int k = 0; k < NUM_FILTERS; k++)
      begin
        mask[k] <= MASK_RESET;
        code[k] <= CODE_RESET;
      end
      port_ctrl <= PORT_CTRL_RESET[1:0];
      port_latch <= PORT_DATA_RESET[7:2];
      port_dir <= PORT_DIR_RESET[7:2];
      soft_reset_request <= MCR0_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      accept_lo <= 1'b0;
      accept_hi <= 1'b0;
      o_port_pin <= '0;
      o_port_pin_oe_n <= '1;
      o_can_transmit_pin <= 1'b1;
    end
    else
    begin
      mask <= next_mask;
      code <= next_code;
      port_ctrl <= next_port_ctrl;
      port_latch <= next_port_latch;
      port_dir <= next_port_dir;
      soft_reset_request <= next_soft_reset_request;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      accept_lo <= next_accept_lo;
      accept_hi <= next_accept_hi;
      o_port_pin <= pin_out;
      o_port_pin_oe_n <= pin_oe_n;
      o_can_transmit_pin <= can_tx;
    end
  end

  assign o_prdata = prdata;
  assign o_pready = pready;
  assign o_pslverr = pslverr;
  assign o_accept_lo = accept_lo;
  assign o_accept_hi = accept_hi;
  assign o_pull_enable = port_ctrl[CTRL_PULL_BIT];
  assign o_reduced_drive_enable = port_ctrl[CTRL_REDUCED_BIT];
  assign o_soft_reset_request = soft_reset_request;

  AST_MASK_LOCKED: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !soft_reset_request |=> $stable(mask[4]) && $stable(mask[7]))
    else $error("mask changed while soft reset request clear");
  AST_MASK_WRITE: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (wr && soft_reset_request && word_idx == IDX_MASK_5)
      |=> mask[5] == $past(wbyte))
    else $error("mask write lost");
  AST_ACCEPT_HI: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_identifier_valid && bank_hit({code[4], code[5], code[6], code[7]},
      {mask[4], mask[5], mask[6], mask[7]}, i_received_identifier_byte))
      |=> accept_hi)
    else $error("accept flag wrong");
  AST_REJECT_HI: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_identifier_valid && !bank_hit({code[4], code[5], code[6], code[7]},
      {mask[4], mask[5], mask[6], mask[7]}, i_received_identifier_byte))
      |=> !accept_hi)
    else $error("mismatching identifier accepted");
  AST_ALL_MASKED: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_identifier_valid && (&{mask[0], mask[1], mask[2], mask[3]}))
      |=> accept_lo)
    else $error("fully masked bank rejected");
  AST_DRIVE_DIR: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    ##1 o_port_pin_oe_n == ~$past(port_dir))
    else $error("pin enable not tied to direction");
  AST_CTRL_ZERO: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (access && !i_pwrite && word_idx == IDX_PORT_CTRL)
      |=> prdata[31:2] == 30'h0)
    else $error("control upper bits not zero");
  AST_RX_READ: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (access && word_idx == IDX_PORT_DATA) |=> prdata[0] == $past(can_sync[0]))
    else $error("receive level not returned");
  AST_DIR_STORE: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (wr && word_idx == IDX_PORT_DIR) |=> port_dir == $past(wbyte[7:2]))
    else $error("direction not stored");
  AST_READY_PULSE: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_psel && !i_penable) ##1 (i_psel && i_penable) |=> pready)
    else $error("apb answer late");
  COV_ACCEPT: cover property (@(posedge i_ref_clk) accept_lo && accept_hi);
  COV_LOCKED_WRITE: cover property (@(posedge i_ref_clk)
    wr && !soft_reset_request && word_idx == IDX_MASK_4);
  COV_OUTPUT_PIN: cover property (@(posedge i_ref_clk) !o_port_pin_oe_n[7]);
endmodule : cmp_mask_port

// file: cmp_pins_model.sv
// board and transceiver model facing the spare port and can pins
`timescale 1ns/100ps
module cmp_pins_model
(
  input wire logic i_tx_pin,
  input wire logic [7:2] i_drive,
  input wire logic [7:2] i_oe_n,
  input wire logic [7:2] i_ext,
  output logic o_rx_pin,
  output logic [7:2] o_pin
);
  // transceiver echoes the bus level; no arbitration loss modelled
  assign o_rx_pin = i_tx_pin;
  // board drives only the pins the block has released
  always_comb
  begin
    for (int k = 2; k < 8; k++)
      o_pin[k] = i_oe_n[k] ? i_ext[k] : i_drive[k];
  end
endmodule : cmp_pins_model

// file: cmp_mask_port_bench.sv
// self-checking bench for the mask and port block
`timescale 1ns/100ps
module cmp_mask_port_bench;
  import cmp_pkg::*;
  logic i_ref_clk = 0;
  logic i_nrst = 0;
  logic psel = 0, pen = 0, pwr = 0, idv = 0, txl = 0, slv;
  logic [13:0] paddr = 0;
  logic [31:0] pwdata = 0, id = 0, prdata, rd, mk, cd, v;
  logic pready, pslverr, acc_lo, acc_hi, txp, rxp, pull, rdrv, srr;
  logic [7:2] pin_in, pin_out, oe_n, ext = 0;
  logic [7:0] m [4], c [4], d, dr;
  int fail_count = 0, num_checks = 0;
  integer seed = 32'h1a50465e;
  always #5 i_ref_clk = ~i_ref_clk;
  cmp_mask_port dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr),
    .i_received_identifier_byte(id), .i_identifier_valid(idv),
    .o_accept_lo(acc_lo), .o_accept_hi(acc_hi), .i_tx_level(txl),
    .o_can_transmit_pin(txp), .i_can_receive_pin(rxp),
    .i_port_pin(pin_in), .o_port_pin(pin_out), .o_port_pin_oe_n(oe_n),
    .o_pull_enable(pull), .o_reduced_drive_enable(rdrv),
    .o_soft_reset_request(srr));
  cmp_pins_model pins (.i_tx_pin(txp), .i_drive(pin_out), .i_oe_n(oe_n),
    .i_ext(ext), .o_rx_pin(rxp), .o_pin(pin_in));
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] idx, input logic [7:0] dt);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, dt};
    @(posedge i_ref_clk);
    pen <= 1'b1;
    @(posedge i_ref_clk);
    // hold the request until pready is seen at an edge
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge i_ref_clk);
      n++;
    end
    if (n == 16)
    begin
      fail_count++;
      report_and_stop;
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task ident(input logic [31:0] val);
    @(posedge i_ref_clk);
    id <= val;
    idv <= 1'b1;
    @(posedge i_ref_clk);
    idv <= 1'b0;
    @(posedge i_ref_clk);
    #1;
  endtask : ident
  function automatic logic hit(input logic [31:0] code, mask, idv_);
    return &(~(code ^ idv_) | mask);
  endfunction : hit
  initial
  begin
    repeat (16) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    apb(0, IDX_PORT_CTRL, 8'h00);
    chk(rd, 32'(PORT_CTRL_RESET));
    for (int k = 0; k < 4; k++)
    begin
      m[k] = 8'($random(seed));
      c[k] = 8'($random(seed));
    end
    m[1][2:0] = 3'b111;
    for (int k = 0; k < 4; k++)
    begin
      apb(1, IDX_MASK_4 + 12'(k), m[k]);
      apb(1, IDX_CODE_0 + 12'(8 + k), c[k]);
      apb(0, IDX_MASK_4 + 12'(k), 8'h00);
      chk(rd, 32'(m[k]));
    end
    mk = {m[0], m[1], m[2], m[3]};
    cd = {c[0], c[1], c[2], c[3]};
    // first flips only masked bits, then one bit at a time
    for (int k = 0; k < 40; k++)
    begin
      v = (k < 8) ? cd ^ (mk & $random(seed)) : cd ^ (32'h1 << (k % 32));
      ident(v);
      chk(32'({acc_lo, acc_hi}), 32'({1'b1, hit(cd, mk, v)}));
    end
    $display("filter test done");
    apb(1, IDX_MODULE_CTRL_0, 8'h00);
    apb(1, IDX_MASK_4, ~m[0]);
    apb(0, IDX_MASK_4, 8'h00);
    chk(32'(srr), 32'h0);
    chk(rd, 32'(m[0]));
    apb(1, IDX_PORT_CTRL, 8'hff);
    apb(0, IDX_PORT_CTRL, 8'h00);
    chk(32'({pull, rdrv}), 32'h3);
    chk(rd, 32'h3);
    apb(1, IDX_PORT_CTRL, 8'h02);
    @(posedge i_ref_clk);
    chk(32'({pull, rdrv}), 32'h2);
    for (int k = 0; k < 6; k++)
    begin
      d = 8'($random(seed));
      dr = (k < 2) ? 8'hfc : (k < 4) ? 8'h00 : 8'($random(seed));
      ext <= 6'($random(seed));
      txl <= k[0];
      apb(1, IDX_PORT_DIR, dr);
      apb(1, IDX_PORT_DATA, d);
      apb(0, IDX_PORT_DIR, 8'h00);
      chk(rd, 32'(dr & 8'hfc));
      repeat (4) @(posedge i_ref_clk);
      apb(0, IDX_PORT_DATA, 8'h00);
      chk(rd, {24'h0, (d[7:2] & dr[7:2]) | (ext & ~dr[7:2]), txl, txl});
      chk(32'({pin_out & dr[7:2], oe_n}), 32'({d[7:2] & dr[7:2], ~dr[7:2]}));
    end
    $display("port test done");
    apb(0, 12'h3ff, 8'h00);
    chk(32'(slv), 32'h1);
    $display("unmapped test done");
    report_and_stop;
  end
endmodule : cmp_mask_port_bench
